// ===== testbench/epiu_checker.sv
// Port-level assertions for the interrupt unit.
// Assumes one clock domain; bound into every epiu_top.
`timescale 1ns/1ps
`default_nettype none
module epiu_checker (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [7:0]  ext_irq_pin_i,
  input wire logic [12:0] change_watch_inputs_i,
  input wire logic        global_irq_enable_i,
  input wire logic [7:0]  ext_vector_ack_i,
  input wire logic [1:0]  change_vector_ack_i,
  input wire logic [7:0]  ext_irq_request_o,
  input wire logic        change_group0_request_o,
  input wire logic        change_group1_request_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_EXT_GIE: assert property (!$past(global_irq_enable_i) |-> ext_irq_request_o == 8'h00)
    else $error("ext request without global enable");
  AST_GRP0_GIE: assert property (!$past(global_irq_enable_i) |-> !change_group0_request_o)
    else $error("group0 request without global enable");
  AST_GRP1_GIE: assert property (!$past(global_irq_enable_i) |-> !change_group1_request_o)
    else $error("group1 request without global enable");
  AST_ACK_ANSWER: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  AST_RDATA_HOLD: assert property (!$stable(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved without a read");
  // Five calm cycles cover sync, flag and request stages
  AST_EXT_QUIET: assert property ((!avs_write_i && $stable(ext_irq_pin_i) &&
    $stable(global_irq_enable_i) && ext_vector_ack_i == 8'h00)[*5] |=> $stable(ext_irq_request_o))
    else $error("ext request moved with quiet inputs");
  AST_CHG_QUIET: assert property ((!avs_write_i && $stable(change_watch_inputs_i) &&
    $stable(global_irq_enable_i) && change_vector_ack_i == 2'h0)[*5] |=>
    $stable({change_group1_request_o, change_group0_request_o}))
    else $error("group request moved with quiet inputs");
  cover property (ext_irq_request_o != 8'h00);
  cover property (change_group0_request_o);
  cover property (change_group1_request_o);
endmodule // epiu_checker
bind epiu_top epiu_checker i_chk (.*);
`default_nettype wire

// ===== testbench/epiu_cpu_model.sv
// CPU vectoring side: acknowledges pending requests after a latency.
// Assumes requests are levels on the unit clock; acks repeat each cycle while requests stay up.
`timescale 1ns/1ps
`default_nettype none
module epiu_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [7:0] ext_req_i,
  input  wire logic [1:0] chg_req_i,
  output logic      [7:0] ext_ack_o = 8'h00,
  output logic      [1:0] chg_ack_o = 2'h0
);
  logic [7:0] wait_r = 8'h00;
  always @(posedge clk_i) begin
    ext_ack_o <= 8'h00;
    chg_ack_o <= 2'h0;
    wait_r    <= 8'h00;
    if (en_i && (ext_req_i != 8'h00 || chg_req_i != 2'h0)) begin
      wait_r <= wait_r + 8'h01;
      if (wait_r >= lat_i) begin
        ext_ack_o <= ext_req_i;
        chg_ack_o <= chg_req_i;
      end
    end
  end
endmodule // epiu_cpu_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the interrupt unit: registers, pins, vectors.
// Assumes epiu_top, the checker and epiu_cpu_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [7:0]  pins = 8'hff;
  logic [12:0] chg = 13'h0;
  logic        gie = 1'b0;
  logic        slp = 1'b0;
  logic        cpu_en = 1'b0;
  logic [7:0]  lat = 8'h00;
  logic [31:0] rdat;
  logic [7:0]  eack, ereq, q;
  logic [1:0]  cack;
  logic        wreq, g0, g1;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  integer      seed = 32'h9883;
  always #5 clk = ~clk;
  epiu_top i_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .ext_irq_pin_i(pins), .change_watch_inputs_i(chg),
    .global_irq_enable_i(gie), .sleep_i(slp), .ext_vector_ack_i(eack),
    .change_vector_ack_i(cack), .ext_irq_request_o(ereq), .change_group0_request_o(g0),
    .change_group1_request_o(g1));
  epiu_cpu_model i_cpu (.clk_i(clk), .en_i(cpu_en), .lat_i(lat), .ext_req_i(ereq),
    .chg_req_i({g1, g0}), .ext_ack_o(eack), .chg_ack_o(cack));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic fexp(input logic [1:0] m, input logic o, input logic v);
    case (m)
      epiu_pkg::EPIU_SENSE_LOW: return 1'b0;
      epiu_pkg::EPIU_SENSE_ANY: return o ^ v;
      epiu_pkg::EPIU_SENSE_FALL: return o & !v;
      default: return !o & v;
    endcase
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin : main
    logic [7:0] n, x, ml, mh;
    logic [1:0] m, en;
    logic o, v, e;
    logic [12:0] d;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00);
      chk("reset value", q, 8'h00);
    end
    bus(1'b1, epiu_pkg::ADDR_CHG_MASK_HI, 8'hff);
    bus(1'b0, epiu_pkg::ADDR_CHG_MASK_HI, 8'h00);
    chk("mask high", q, 8'h1f);
    bus(1'b1, epiu_pkg::ADDR_CHG_ENABLE, 8'hff);
    bus(1'b0, epiu_pkg::ADDR_CHG_ENABLE, 8'h00);
    chk("group enable", q, 8'h03);
    be <= 4'h0;
    bus(1'b1, epiu_pkg::ADDR_CHG_MASK_LO, 8'h5a);
    be <= 4'hf;
    bus(1'b0, epiu_pkg::ADDR_CHG_MASK_LO, 8'h00);
    chk("masked write", q, 8'h00);
    for (int i = 0; i < 24; i++) begin
      n = (i < 8) ? 8'(i / 4 * 4) : 8'($unsigned($random(seed)) % 8);
      m = (i < 8) ? 2'(i) : 2'($random(seed));
      o = 1'($random(seed));
      v = (i < 8) ? !o : 1'($random(seed));
      gie <= 1'b0;
      bus(1'b1, epiu_pkg::ADDR_EXT_MASK, 8'h00);
      bus(1'b1, n < 4 ? epiu_pkg::ADDR_LOW_SENSE : epiu_pkg::ADDR_HIGH_SENSE, 8'(m) << (n % 4 * 2));
      pins <= 8'hff ^ (8'(!o) << n);
      repeat (6) @(posedge clk);
      bus(1'b1, epiu_pkg::ADDR_EXT_FLAGS, 8'hff);
      pins <= 8'hff ^ (8'(!v) << n);
      repeat (6) @(posedge clk);
      e = fexp(m, o, v);
      bus(1'b1, epiu_pkg::ADDR_EXT_FLAGS, 8'h00);
      bus(1'b0, epiu_pkg::ADDR_EXT_FLAGS, 8'h00);
      chk("ext flags", q, 8'(e) << n);
      bus(1'b1, epiu_pkg::ADDR_EXT_MASK, 8'h01 << n);
      gie <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ext request", ereq, 8'(m == 2'h0 ? !v : e) << n);
      lat <= 8'($unsigned($random(seed)) % 8);
      cpu_en <= 1'b1;
      repeat (16) @(posedge clk);
      chk("ext request", ereq, 8'(m == 2'h0 ? !v : 1'b0) << n);
      cpu_en <= 1'b0;
      bus(1'b0, epiu_pkg::ADDR_EXT_FLAGS, 8'h00);
      chk("ext flags", q, 8'h00);
    end
    // Sleep with pin 0 masked off: its buffer reads high and sets the flag
    bus(1'b1, epiu_pkg::ADDR_EXT_MASK, 8'h00);
    bus(1'b1, epiu_pkg::ADDR_LOW_SENSE, 8'h01);
    pins <= 8'hfe;
    repeat (6) @(posedge clk);
    bus(1'b1, epiu_pkg::ADDR_EXT_FLAGS, 8'hff);
    slp <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, epiu_pkg::ADDR_EXT_FLAGS, 8'h00);
    chk("sleep flags", q, 8'h01);
    slp <= 1'b0;
    gie <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      en = (i == 0) ? 2'h3 : 2'($random(seed));
      ml = (i == 0) ? 8'hff : 8'($random(seed));
      mh = (i == 0) ? 8'h1f : 8'($random(seed));
      d = (i == 0) ? 13'h1fff : 13'($random(seed));
      bus(1'b1, epiu_pkg::ADDR_CHG_ENABLE, 8'(en));
      bus(1'b1, epiu_pkg::ADDR_CHG_MASK_LO, ml);
      bus(1'b1, epiu_pkg::ADDR_CHG_MASK_HI, mh);
      repeat (6) @(posedge clk);
      bus(1'b1, epiu_pkg::ADDR_CHG_FLAGS, 8'h03);
      chg <= chg ^ d;
      repeat (6) @(posedge clk);
      x = {6'h0, en[1] & |(d[12:8] & mh[4:0]), en[0] & |(d[7:0] & ml)};
      bus(1'b0, epiu_pkg::ADDR_CHG_FLAGS, 8'h00);
      chk("group flags", q, x);
      chk("group request", {6'h0, g1, g0}, x);
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire

// ===== verilog/epiu_pkg.sv
// Package for the external and pin-change interrupt unit.
// Assumes a 32-bit Avalon-MM register bus, byte addresses, one word per register.
package epiu_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_LOW_SENSE   = 5'h00;
  localparam logic [4:0] ADDR_HIGH_SENSE  = 5'h04;
  localparam logic [4:0] ADDR_EXT_MASK    = 5'h08;
  localparam logic [4:0] ADDR_EXT_FLAGS   = 5'h0c;
  localparam logic [4:0] ADDR_CHG_ENABLE  = 5'h10;
  localparam logic [4:0] ADDR_CHG_FLAGS   = 5'h14;
  localparam logic [4:0] ADDR_CHG_MASK_LO = 5'h18;
  localparam logic [4:0] ADDR_CHG_MASK_HI = 5'h1c;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [4:0] RST_HI5  = 5'h00;
  // Idle levels seen by the synchronisers in reset
  localparam logic [7:0]  PIN_IDLE = 8'hff;
  localparam logic [12:0] CHG_IDLE = 13'h0000;
  // Bits per sense field
  localparam int SENSE_W = 2;

  // Field widths and layout
  localparam int N_EXT       = 8;
  localparam int N_LOW_GRP   = 4;
  localparam int N_CHG       = 13;
  localparam int N_CHG_LO    = 8;
  localparam int N_CHG_HI    = 5;
  localparam int CHG_GRP_W   = 2;
  localparam int GRP0        = 0;
  localparam int GRP1        = 1;

  // Sense field encodings
  typedef enum logic [1:0] {
    EPIU_SENSE_LOW  = 2'h0,
    EPIU_SENSE_ANY  = 2'h1,
    EPIU_SENSE_FALL = 2'h2,
    EPIU_SENSE_RISE = 2'h3
  } epiu_sense_t;

endpackage : epiu_pkg

// ===== verilog/epiu_top.sv
// External pin and pin-change interrupt unit, single clock, Avalon-MM slave.
// Assumes the CPU pulses vector-entry acknowledges and drives the global flag.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module epiu_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Pins and CPU side
  input  wire logic [7:0]  ext_irq_pin_i,
  input  wire logic [12:0] change_watch_inputs_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        sleep_i,
  input  wire logic [7:0]  ext_vector_ack_i,
  input  wire logic [1:0]  change_vector_ack_i,
  output logic      [7:0]  ext_irq_request_o,
  output logic             change_group0_request_o,
  output logic             change_group1_request_o
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic [7:0]  pin_sync_r;
  logic [7:0]  pin_prev_r;
  logic [12:0] chg_sync_r;
  logic [12:0] chg_prev_r;
  logic [7:0]  low_group_sense_control_r;
  logic [7:0]  high_group_sense_control_r;
  logic [7:0]  external_interrupt_mask_r;
  logic [7:0]  external_interrupt_flags_r;
  logic [1:0]  pin_change_group_enable_r;
  logic [1:0]  pin_change_group_flags_r;
  logic [7:0]  pin_change_mask_low_r;
  logic [4:0]  pin_change_mask_high_r;
  logic        ack_pending_r;
  logic [7:0]  ext_irq_request_r;
  logic [1:0]  chg_request_r;
  logic [7:0]  pin_eff;
  logic [7:0]  trig_nxt;
  logic [7:0]  level_nxt;
  logic [12:0] chg_diff;
  logic [1:0]  grp_trig_nxt;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_nxt;
  logic [1:0]  pin_sense [epiu_pkg::N_EXT];
  logic [7:0]  ext_flag_clr;
  logic [7:0]  ext_flag_zero;
  logic [1:0]  grp_flag_clr;
  logic        waitreq_r;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pin synchronisers; pin levels come in whatever the pin direction is
  epiu_sync2 #(
    .W    (epiu_pkg::N_EXT),
    .INIT (epiu_pkg::PIN_IDLE)
  ) i_pin_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_sync_r),
    .d_i     (ext_irq_pin_i),
    .q_o     (pin_sync_r)
  );

  // Pin-change inputs take the same two-flop path
  epiu_sync2 #(
    .W    (epiu_pkg::N_CHG),
    .INIT (epiu_pkg::CHG_IDLE)
  ) i_chg_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_sync_r),
    .d_i     (change_watch_inputs_i),
    .q_o     (chg_sync_r)
  );

  // Previous samples for edge and change compare
  // Reset to the idle levels so release gives no false edge
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_prev_r <= epiu_pkg::PIN_IDLE;
      chg_prev_r <= epiu_pkg::CHG_IDLE;
    end else begin
      pin_prev_r <= pin_eff;
      chg_prev_r <= chg_sync_r;
    end
  end

  // Sleep with low group disabled forces disabled buffers to read high.
  // Single-clock model: asynchronous capture is stood in by the sync path.
  always_comb begin
    pin_eff = pin_sync_r;
    for (int i = 0; i < epiu_pkg::N_LOW_GRP; i++) begin
      if (sleep_i && !external_interrupt_mask_r[i]) begin
        pin_eff[i] = 1'b1;
      end
    end
  end

  // Sense field per pin, low group in the low slots
  always_comb begin
    for (int i = 0; i < epiu_pkg::N_LOW_GRP; i++) begin
      pin_sense[i] = low_group_sense_control_r[epiu_pkg::SENSE_W*i +: epiu_pkg::SENSE_W];
    end
    for (int i = 0; i < epiu_pkg::N_EXT - epiu_pkg::N_LOW_GRP; i++) begin
      pin_sense[i+epiu_pkg::N_LOW_GRP] =
        high_group_sense_control_r[epiu_pkg::SENSE_W*i +: epiu_pkg::SENSE_W];
    end
  end

  // Sense decode per pin
  // Edge modes compare with the previous sample; level mode needs no history
  always_comb begin
    trig_nxt  = 8'h00;
    level_nxt = 8'h00;
    for (int i = 0; i < epiu_pkg::N_EXT; i++) begin
      unique case (epiu_pkg::epiu_sense_t'(pin_sense[i]))
        epiu_pkg::EPIU_SENSE_LOW:  level_nxt[i] = ~pin_eff[i];
        epiu_pkg::EPIU_SENSE_ANY:  trig_nxt[i] = pin_eff[i] ^ pin_prev_r[i];
        epiu_pkg::EPIU_SENSE_FALL: trig_nxt[i] = pin_prev_r[i] & ~pin_eff[i];
        epiu_pkg::EPIU_SENSE_RISE: trig_nxt[i] = ~pin_prev_r[i] & pin_eff[i];
      endcase
    end
  end

  // Group change detection
  always_comb begin
    chg_diff = chg_sync_r ^ chg_prev_r;
    grp_trig_nxt[epiu_pkg::GRP0] = |(chg_diff[7:0] & pin_change_mask_low_r)
                                   & pin_change_group_enable_r[epiu_pkg::GRP0];
    grp_trig_nxt[epiu_pkg::GRP1] = |(chg_diff[12:8] & pin_change_mask_high_r)
                                   & pin_change_group_enable_r[epiu_pkg::GRP1];
  end

  // A write lands at the edge where the master sees waitrequest low
  assign wr_hit = avs_write_i && ack_pending_r && avs_byteenable_i[0];
  assign rd_hit = avs_read_i && !ack_pending_r;

  // Control registers
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      low_group_sense_control_r  <= epiu_pkg::RST_BYTE;
      high_group_sense_control_r <= epiu_pkg::RST_BYTE;
      external_interrupt_mask_r  <= epiu_pkg::RST_BYTE;
      pin_change_group_enable_r  <= epiu_pkg::RST_PAIR;
      pin_change_mask_low_r      <= epiu_pkg::RST_BYTE;
      pin_change_mask_high_r     <= epiu_pkg::RST_HI5;
    end else if (wr_hit) begin
      unique case (avs_address_i)
        epiu_pkg::ADDR_LOW_SENSE:   low_group_sense_control_r <= avs_writedata_i[7:0];
        epiu_pkg::ADDR_HIGH_SENSE:  high_group_sense_control_r <= avs_writedata_i[7:0];
        epiu_pkg::ADDR_EXT_MASK:    external_interrupt_mask_r <= avs_writedata_i[7:0];
        epiu_pkg::ADDR_CHG_ENABLE:  pin_change_group_enable_r <= avs_writedata_i[1:0];
        epiu_pkg::ADDR_CHG_MASK_LO: pin_change_mask_low_r <= avs_writedata_i[7:0];
        epiu_pkg::ADDR_CHG_MASK_HI: pin_change_mask_high_r <= avs_writedata_i[4:0];
        default: ;
      endcase
    end
  end

  // Clear and hold-zero terms for the flag cells
  always_comb begin
    ext_flag_clr  = 8'h00;
    ext_flag_zero = 8'h00;
    grp_flag_clr  = 2'h0;
    for (int i = 0; i < epiu_pkg::N_EXT; i++) begin
      ext_flag_clr[i]  = ext_vector_ack_i[i] ||
                         (wr_hit && avs_address_i == epiu_pkg::ADDR_EXT_FLAGS &&
                          avs_writedata_i[i]);
      ext_flag_zero[i] = pin_sense[i] == epiu_pkg::EPIU_SENSE_LOW;
    end
    for (int g = 0; g < epiu_pkg::CHG_GRP_W; g++) begin
      grp_flag_clr[g] = change_vector_ack_i[g] ||
                        (wr_hit && avs_address_i == epiu_pkg::ADDR_CHG_FLAGS &&
                         avs_writedata_i[g]);
    end
  end

  // External flags: set beats clear, level pins hold zero
  for (genvar i = 0; i < epiu_pkg::N_EXT; i++) begin : g_ext_flag
    epiu_flag_cell i_flag (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_sync_r),
      .set_i   (trig_nxt[i]),
      .clr_i   (ext_flag_clr[i]),
      .zero_i  (ext_flag_zero[i]),
      .flag_o  (external_interrupt_flags_r[i])
    );
  end

  // Group flags: set beats clear, never held at zero
  for (genvar g = 0; g < epiu_pkg::CHG_GRP_W; g++) begin : g_grp_flag
    epiu_flag_cell i_flag (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_sync_r),
      .set_i   (grp_trig_nxt[g]),
      .clr_i   (grp_flag_clr[g]),
      .zero_i  (1'b0),
      .flag_o  (pin_change_group_flags_r[g])
    );
  end

  // Requests toward the CPU vectoring logic
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ext_irq_request_r <= epiu_pkg::RST_BYTE;
      chg_request_r     <= epiu_pkg::RST_PAIR;
    end else begin
      for (int i = 0; i < epiu_pkg::N_EXT; i++) begin
        ext_irq_request_r[i] <= global_irq_enable_i && external_interrupt_mask_r[i] &&
                                (external_interrupt_flags_r[i] || level_nxt[i]);
      end
      for (int g = 0; g < epiu_pkg::CHG_GRP_W; g++) begin
        chg_request_r[g] <= global_irq_enable_i && pin_change_group_enable_r[g] &&
                            pin_change_group_flags_r[g];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (avs_address_i)
      epiu_pkg::ADDR_LOW_SENSE:   rd_nxt[7:0] = low_group_sense_control_r;
      epiu_pkg::ADDR_HIGH_SENSE:  rd_nxt[7:0] = high_group_sense_control_r;
      epiu_pkg::ADDR_EXT_MASK:    rd_nxt[7:0] = external_interrupt_mask_r;
      epiu_pkg::ADDR_EXT_FLAGS:   rd_nxt[7:0] = external_interrupt_flags_r;
      epiu_pkg::ADDR_CHG_ENABLE:  rd_nxt[1:0] = pin_change_group_enable_r;
      epiu_pkg::ADDR_CHG_FLAGS:   rd_nxt[1:0] = pin_change_group_flags_r;
      epiu_pkg::ADDR_CHG_MASK_LO: rd_nxt[7:0] = pin_change_mask_low_r;
      epiu_pkg::ADDR_CHG_MASK_HI: rd_nxt[4:0] = pin_change_mask_high_r;
      default:                    rd_nxt = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access, then answer
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ack_pending_r  <= 1'b0;
      waitreq_r      <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_pending_r <= (avs_read_i || avs_write_i) && !ack_pending_r;
      // Own flop, so the port needs no inverter after the register
      waitreq_r     <= !((avs_read_i || avs_write_i) && !ack_pending_r);
      if (rd_hit) begin
        avs_readdata_o <= rd_nxt;
      end
    end
  end

  assign avs_waitrequest_o       = waitreq_r;
  assign ext_irq_request_o       = ext_irq_request_r;
  assign change_group0_request_o = chg_request_r[epiu_pkg::GRP0];
  assign change_group1_request_o = chg_request_r[epiu_pkg::GRP1];

endmodule // epiu_top

// Two-flop synchroniser for levels from outside the clock domain
module epiu_sync2 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Raw and settled levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // Only the second stage is read; the first may be metastable
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= INIT;
      q_o    <= INIT;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // epiu_sync2

// One interrupt flag: hold-zero first, then set, then clear
module epiu_flag_cell (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Events
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic zero_i,
  // Flag
  output logic      flag_o
);

  // A trigger in the cycle of a clear wins, so no event is lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (zero_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // epiu_flag_cell

`default_nettype wire
